// File: design/nco_cfg_pkg.sv
// Constants shared by the oscillator configuration block.
// Assumes a 13-bit address space of 8-bit registers behind a 3-wire serial port.
package nco_cfg_pkg;
    // Register addresses
    localparam logic [12:0] ADDR_OUT_MODE = 13'h014;
    localparam logic [12:0] ADDR_OSC_CTRL = 13'h11d;
    localparam logic [12:0] ADDR_FREQ_B0 = 13'h11e;
    localparam logic [12:0] ADDR_FREQ_B1 = 13'h11f;
    localparam logic [12:0] ADDR_FREQ_B2 = 13'h120;
    localparam logic [12:0] ADDR_FREQ_B3 = 13'h121;
    localparam logic [12:0] ADDR_PHASE_LO = 13'h122;
    localparam logic [12:0] ADDR_PHASE_HI = 13'h123;
    // Field positions
    localparam int OSC_EN_BIT = 0;
    localparam int AMP_DITHER_BIT = 1;
    localparam int PHASE_DITHER_BIT = 2;
    localparam int LVDS_SEL_BIT = 0;
    localparam int INSTR_RW_BIT = 15;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Serial framing
    localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    typedef enum logic [0:0] {ST_INSTR, ST_DATA} spi_state_t;
endpackage

// File: design/bit_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the level is stable for several clk_sys periods.
module bit_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Level in and out
    input wire logic asyncIn,
    input wire logic rstVal,
    output logic syncOut
);
    logic meta_r;

    // First stage only feeds the second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_r <= rstVal;
            syncOut <= rstVal;
        end else begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule

// File: design/nco_tuning_phase_config.sv
// Oscillator tuning, start phase and output mode configuration with serial port.
// Assumes serial clock far slower than clk_sys (at most one edge per four cycles).
// Operation
// - Tuning word assembled from four bytes, LSB first
// - Tuning word added as signed twos complement
// - Start phase from two bytes, low first
// - Oscillator start loads start phase
// - Sync event reloads start phase while oscillator enabled
// - Outputs default to CMOS after reset
// - Disable pin high turns outputs off
// - Enable runs oscillator, clear parks its accumulator at zero
module nco_tuning_phase_config (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial port pins
    input wire logic sclkPin,
    input wire logic serial_select_low,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    // Control pins
    input wire logic output_disable_pin,
    input wire logic syncPin,
    // Oscillator side
    output logic [31:0] tuning_word,
    output logic [15:0] start_phase_code,
    output logic oscillator_enable,
    output logic ampDither,
    output logic phaseDither,
    output logic [31:0] phaseAcc,
    output logic phaseLoad,
    // Output stage control
    output logic lvdsMode,
    output logic dataOutEnable
);
    logic sclkS;
    logic selLowS;
    logic sdioS;
    logic disS;
    logic syncS;
    logic sclkD_r;
    logic syncD_r;
    logic oscEnD_r;
    logic [7:0] freqB0_r;
    logic [7:0] freqB1_r;
    logic [7:0] freqB2_r;
    logic [7:0] freqB3_r;
    logic [7:0] phaseLo_r;
    logic [7:0] phaseHi_r;
    logic [7:0] ctrl_r;
    logic [7:0] mode_r;
    logic [15:0] phaseHeld_r;
    logic [31:0] acc_r;
    logic [31:0] accNxt;
    logic loadPulse_r;
    nco_cfg_pkg::spi_state_t state_r;
    logic [3:0] bitCnt_r;
    logic [15:0] shiftIn_r;
    logic [7:0] rdShift_r;
    logic [12:0] addr_r;
    logic readMode_r;
    logic sdio_r;

    // Every pin from outside passes two flops
    bit_sync uSclk (.clk_sys(clk_sys), .sys_rst(sys_rst), .asyncIn(sclkPin), .rstVal(1'b0), .syncOut(sclkS));
    bit_sync uSel (.clk_sys(clk_sys), .sys_rst(sys_rst), .asyncIn(~serial_select_low), .rstVal(1'b0),
        .syncOut(selLowS));
    bit_sync uSdio (.clk_sys(clk_sys), .sys_rst(sys_rst), .asyncIn(sdioIn), .rstVal(1'b0), .syncOut(sdioS));
    bit_sync uDis (.clk_sys(clk_sys), .sys_rst(sys_rst), .asyncIn(~output_disable_pin), .rstVal(1'b0),
        .syncOut(disS));
    bit_sync uSync (.clk_sys(clk_sys), .sys_rst(sys_rst), .asyncIn(syncPin), .rstVal(1'b0), .syncOut(syncS));

    // Synchronisers reset to 0, so select and enable pass inverted: idle and off during reset
    wire selActive = selLowS; // Pin was inverted ahead of the flops, so high here means selected
    wire outsAllowed = disS;
    wire sclkRise = sclkS & ~sclkD_r;
    wire sclkFall = ~sclkS & sclkD_r;
    wire frameIdle = ~selActive;
    wire instrDone = (state_r == nco_cfg_pkg::ST_INSTR) && sclkRise && (bitCnt_r == nco_cfg_pkg::INSTR_LAST_BIT);
    wire byteDone = (state_r == nco_cfg_pkg::ST_DATA) && sclkRise
        && (bitCnt_r[2:0] == nco_cfg_pkg::BYTE_LAST_BIT);
    wire [15:0] instrWord = {shiftIn_r[14:0], sdioS};
    wire [7:0] dataByte = {shiftIn_r[6:0], sdioS};
    wire wrStrobe = byteDone && !readMode_r;
    wire [12:0] rdAddr = instrDone ? instrWord[12:0] : addr_r + 13'h001;

    // Readback select; unmapped addresses read as zero
    wire [7:0] rdData =
        (rdAddr == nco_cfg_pkg::ADDR_FREQ_B0) ? freqB0_r :
        (rdAddr == nco_cfg_pkg::ADDR_FREQ_B1) ? freqB1_r :
        (rdAddr == nco_cfg_pkg::ADDR_FREQ_B2) ? freqB2_r :
        (rdAddr == nco_cfg_pkg::ADDR_FREQ_B3) ? freqB3_r :
        (rdAddr == nco_cfg_pkg::ADDR_PHASE_LO) ? phaseLo_r :
        (rdAddr == nco_cfg_pkg::ADDR_PHASE_HI) ? phaseHi_r :
        (rdAddr == nco_cfg_pkg::ADDR_OSC_CTRL) ? ctrl_r :
        (rdAddr == nco_cfg_pkg::ADDR_OUT_MODE) ? mode_r : 8'h00;

    // Serial framing: 16-bit instruction then streamed bytes
    always_ff @(posedge clk_sys) begin
        if (sys_rst || frameIdle) begin
            state_r <= nco_cfg_pkg::ST_INSTR;
            bitCnt_r <= 4'h0;
            shiftIn_r <= 16'h0000;
            readMode_r <= 1'b0;
        end else if (sclkRise) begin
            shiftIn_r <= instrWord;
            bitCnt_r <= (instrDone || byteDone) ? 4'h0 : bitCnt_r + 4'h1;
            if (instrDone) begin
                state_r <= nco_cfg_pkg::ST_DATA;
                readMode_r <= instrWord[nco_cfg_pkg::INSTR_RW_BIT];
            end
        end
    end

    // Address and readback shifter; address steps up after each byte
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_r <= 13'h0000;
            rdShift_r <= 8'h00;
            sdio_r <= 1'b0;
        end else if (instrDone || byteDone) begin
            addr_r <= rdAddr;
            rdShift_r <= rdData;
        end else if (sclkFall && state_r == nco_cfg_pkg::ST_DATA && readMode_r && selActive) begin
            sdio_r <= rdShift_r[7];
            rdShift_r <= {rdShift_r[6:0], 1'b0};
        end
    end

    // Configuration bytes; no shadowing, each byte lands on its own write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            freqB0_r <= nco_cfg_pkg::RST_BYTE;
            freqB1_r <= nco_cfg_pkg::RST_BYTE;
            freqB2_r <= nco_cfg_pkg::RST_BYTE;
            freqB3_r <= nco_cfg_pkg::RST_BYTE;
            phaseLo_r <= nco_cfg_pkg::RST_BYTE;
            phaseHi_r <= nco_cfg_pkg::RST_BYTE;
            ctrl_r <= nco_cfg_pkg::RST_BYTE;
            mode_r <= nco_cfg_pkg::RST_BYTE;
        end else if (wrStrobe) begin
            if (addr_r == nco_cfg_pkg::ADDR_FREQ_B0) begin
                freqB0_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_FREQ_B1) begin
                freqB1_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_FREQ_B2) begin
                freqB2_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_FREQ_B3) begin
                freqB3_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_PHASE_LO) begin
                phaseLo_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_PHASE_HI) begin
                phaseHi_r <= dataByte;
            end else if (addr_r == nco_cfg_pkg::ADDR_OSC_CTRL) begin
                ctrl_r <= {5'h00, dataByte[2:0]};
            end else if (addr_r == nco_cfg_pkg::ADDR_OUT_MODE) begin
                mode_r <= {7'h00, dataByte[0]};
            end
        end
    end

    // Word assembly, lowest address in the low byte
    assign tuning_word = {freqB3_r, freqB2_r, freqB1_r, freqB0_r};
    assign start_phase_code = phaseHeld_r;
    assign oscillator_enable = ctrl_r[nco_cfg_pkg::OSC_EN_BIT];
    assign ampDither = ctrl_r[nco_cfg_pkg::AMP_DITHER_BIT];
    assign phaseDither = ctrl_r[nco_cfg_pkg::PHASE_DITHER_BIT];

    // Start is the enable rising; sync is the synced pin rising
    wire startEvt = oscillator_enable & ~oscEnD_r;
    wire syncEvt = syncS & ~syncD_r;
    wire loadEvt = startEvt | (syncEvt & oscillator_enable);

    // Accumulator: parked at zero while disabled, else load phase, else step by signed word
    always_comb begin
        accNxt = acc_r + tuning_word;
        if (!oscillator_enable) begin
            accNxt = nco_cfg_pkg::RST_WORD;
        end else if (loadEvt) begin
            accNxt = {phaseHi_r, phaseLo_r, 16'h0000};
        end
    end

    // Edge history, accumulator and held phase
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sclkD_r <= 1'b0;
            syncD_r <= 1'b0;
            oscEnD_r <= 1'b0;
            acc_r <= nco_cfg_pkg::RST_WORD;
            phaseHeld_r <= 16'h0000;
            loadPulse_r <= 1'b0;
        end else begin
            sclkD_r <= sclkS;
            syncD_r <= syncS;
            oscEnD_r <= oscillator_enable;
            acc_r <= accNxt;
            loadPulse_r <= loadEvt;
            // Phase writes stay invisible until an event
            if (loadEvt) begin
                phaseHeld_r <= {phaseHi_r, phaseLo_r};
            end
        end
    end

    assign phaseAcc = acc_r;
    assign phaseLoad = loadPulse_r;

    // Output stage: mode from register, gated by the disable pin
    assign lvdsMode = mode_r[nco_cfg_pkg::LVDS_SEL_BIT];
    assign dataOutEnable = outsAllowed;

    // Drive the data pin only in the data phase of a read
    assign sdioOut = sdio_r;
    assign sdioOe = selActive && readMode_r && (state_r == nco_cfg_pkg::ST_DATA);
endmodule

// File: test/nco_cfg_chk.sv
// Port checker for the oscillator configuration block.
// Assumes it is bound onto nco_tuning_phase_config.
module nco_cfg_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Watched ports
    input wire logic output_disable_pin,
    input wire logic syncPin,
    input wire logic [31:0] tuning_word,
    input wire logic [15:0] start_phase_code,
    input wire logic oscillator_enable,
    input wire logic [31:0] phaseAcc,
    input wire logic phaseLoad,
    input wire logic lvdsMode,
    input wire logic dataOutEnable
);
    timeunit 1ns;
    timeprecision 1ns;
    // Load and step relations of the accumulator
    AST_LOAD_VAL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        phaseLoad |-> phaseAcc == {start_phase_code, 16'h0000}) else $error("load value wrong");
    AST_EN_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(oscillator_enable) |-> ##[0:1] phaseLoad) else $error("no load at start");
    AST_SYNC_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(syncPin) && oscillator_enable |-> ##[1:8] phaseLoad) else $error("no load at sync");
    AST_ACC_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        oscillator_enable && $past(oscillator_enable) && !phaseLoad
        |-> phaseAcc == $past(phaseAcc) + $past(tuning_word)) else $error("step wrong");
    AST_OFF_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !oscillator_enable && !$past(oscillator_enable) |-> phaseAcc == 32'h0) else $error("acc not idle");
    // Phase only moves at a load, so a write never jolts a running tone
    AST_PHASE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $changed(start_phase_code) |-> phaseLoad) else $error("phase moved");
    // Output gating, two flop latency on the pin
    AST_OE_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        output_disable_pin [*3] |-> !dataOutEnable) else $error("outputs on");
    AST_OE_ON: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !output_disable_pin [*5] |-> dataOutEnable) else $error("outputs off");
    // Reset itself is the cause here, so no disable
    AST_RST_VAL: assert property (@(posedge clk_sys)
        sys_rst |=> !lvdsMode && !oscillator_enable && tuning_word == 32'h0) else $error("reset values");
endmodule

// File: test/spi_host_model.sv
// Serial host model for the three-wire configuration port.
// Assumes clk_sys runs free; one byte per frame.
module spi_host_model (
    // Clock
    input wire logic clk_sys,
    // Serial pins
    output logic sclkPin,
    output logic serial_select_low,
    output logic sdioIn,
    input wire logic sdioOut,
    input wire logic sdioOe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hostOe = 1'b0;
    logic hostBit = 1'b0;
    // Shared data line with pull-up when nobody drives
    assign sdioIn = hostOe ? hostBit : (sdioOe ? sdioOut : 1'b1);
    // Port idle between frames: clock still, select high
    initial begin
        sclkPin = 1'b0;
        serial_select_low = 1'b1;
    end
    // Six-clock half periods, well over the sampler minimum
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] rdv);
        logic [23:0] sh;
        sh = {rd, 2'b00, a, wd};
        rdv = 8'h00;
        @(negedge clk_sys);
        serial_select_low = 1'b0;
        for (int i = 0; i < 24; i++) begin
            @(negedge clk_sys);
            sclkPin = 1'b0;
            hostOe = !(rd && i >= 16);
            hostBit = sh[23 - i];
            repeat (6) @(negedge clk_sys);
            rdv = {rdv[6:0], sdioIn};
            sclkPin = 1'b1;
            repeat (5) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        sclkPin = 1'b0;
        hostOe = 1'b0;
        repeat (6) @(negedge clk_sys);
        serial_select_low = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the oscillator configuration block.
// Assumes spi_host_model and nco_cfg_chk are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, sys_rst, output_disable_pin, syncPin, sclkPin, serial_select_low, sdioIn, sdioOut, sdioOe;
    logic oscillator_enable, ampDither, phaseDither, phaseLoad, lvdsMode, dataOutEnable, hit;
    logic [31:0] tuning_word, phaseAcc, tw, a0, a1;
    logic [15:0] start_phase_code, ph0, ph1;
    logic [7:0] rb;
    int errTotal = 0;
    int nChecks = 0;
    nco_tuning_phase_config dut (.clk_sys, .sys_rst, .sclkPin, .serial_select_low, .sdioIn, .sdioOut, .sdioOe,
        .output_disable_pin, .syncPin, .tuning_word, .start_phase_code, .oscillator_enable, .ampDither,
        .phaseDither, .phaseAcc, .phaseLoad, .lvdsMode, .dataOutEnable);
    spi_host_model host (.clk_sys, .sclkPin, .serial_select_low, .sdioIn, .sdioOut, .sdioOe);
    // 50 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b0, a, d, x);
    endtask
    task automatic rd(input logic [12:0] a);
        host.xfer(1'b1, a, 8'h00, rb);
    endtask
    // Host side phase code, truncated
    function automatic logic [15:0] phase_code(input int deg);
        return 16'((deg * 65536) / 360);
    endfunction
    // Bounded watch for the load pulse, runs beside the frame
    task automatic wait_load();
        hit = 1'b0;
        for (int i = 0; i < 400 && hit !== 1'b1; i++) begin
            @(negedge clk_sys);
            hit = phaseLoad;
            a0 = phaseAcc;
        end
        @(negedge clk_sys);
        a1 = phaseAcc;
    endtask
    task automatic pulse_sync();
        @(negedge clk_sys);
        syncPin = 1'b1;
        repeat (4) @(negedge clk_sys);
        syncPin = 1'b0;
    endtask
    task automatic expect_load(input logic [15:0] code);
        if (hit !== 1'b1) begin
            errTotal++;
            final_report();
        end else begin
            chk(a0, {code, 16'h0000});
            chk(a1, a0 + tw);
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        output_disable_pin = 1'b1;
        syncPin = 1'b0;
        void'($urandom(27970));
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(lvdsMode, 1'b0);
        chk(dataOutEnable, 1'b0);
        wr(nco_cfg_pkg::ADDR_OUT_MODE, 8'h01);
        rd(nco_cfg_pkg::ADDR_OUT_MODE);
        chk({lvdsMode, rb}, 9'h101);
        output_disable_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(dataOutEnable, 1'b1);
        tw = $urandom() | 32'h8000_0000; // negative step wraps the accumulator
        ph0 = phase_code($urandom_range(359));
        ph1 = phase_code(180);
        for (int i = 0; i < 4; i++)
            wr(nco_cfg_pkg::ADDR_FREQ_B0 + 13'(i), tw[8*i +: 8]);
        chk(tuning_word, tw);
        rd(nco_cfg_pkg::ADDR_FREQ_B3);
        chk(rb, tw[31:24]);
        rd(13'h1ff);
        chk(rb, 8'h00);
        wr(nco_cfg_pkg::ADDR_PHASE_LO, ph0[7:0]);
        wr(nco_cfg_pkg::ADDR_PHASE_HI, ph0[15:8]);
        chk(start_phase_code, 16'h0000);
        fork wr(nco_cfg_pkg::ADDR_OSC_CTRL, 8'h07); wait_load(); join
        expect_load(ph0);
        chk({phaseDither, ampDither}, 2'b11);
        wr(nco_cfg_pkg::ADDR_PHASE_LO, ph1[7:0]);
        wr(nco_cfg_pkg::ADDR_PHASE_HI, ph1[15:8]);
        chk(start_phase_code, ph0);
        fork pulse_sync(); wait_load(); join
        expect_load(ph1);
        wr(nco_cfg_pkg::ADDR_OSC_CTRL, 8'h00);
        chk(phaseAcc, 32'h0);
        fork pulse_sync(); wait_load(); join
        chk(hit, 1'b0);
        final_report();
    end
endmodule
bind nco_tuning_phase_config nco_cfg_chk chk_i (.clk_sys, .sys_rst, .output_disable_pin, .syncPin, .tuning_word,
    .start_phase_code, .oscillator_enable, .phaseAcc, .phaseLoad, .lvdsMode, .dataOutEnable);
